// ===== gtm_consts.svh
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH

// ----------------------------------------
// Count and field constants
// ----------------------------------------
`define GTM_COUNT_W 16
`define GTM_COUNT_RST 16'h0000
`define GTM_COUNT_MAX 16'hffff
`define GTM_FLAG_BIT 0
`define GTM_IE_BIT 0
`define GTM_SRC_PIN 2'h0
`define GTM_SRC_T2_MATCH 2'h1
`define GTM_SRC_CMP1 2'h2
`define GTM_SRC_CMP2 2'h3
`define GTM_SCS_SECONDARY 2'h1
`define GTM_IDLE_BIT 7
`define GTM_SOSC_ACTIVE_BIT 6
`define GTM_DRIVE_LOW 2'h1
`define GTM_DRIVE_HIGH 2'h3
`define GTM_T2_W 8
`define GTM_T2_RST 8'h00

`endif

// ===== gtm_gate_if.sv
`default_nettype none

interface gtm_gate_if;
  logic gate_level;

  modport src (output gate_level);
  modport dst (input gate_level);
endinterface

`default_nettype wire

// ===== gtm_gate_sel.sv
`include "gtm_consts.svh"
`default_nettype none

// Second timer, its period-match pulse, and the gate source mux
module gtm_gate_sel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic t2_enable,
  input wire logic [`GTM_T2_W-1:0] second_timer_period,
  input wire logic [1:0] gate_source_select,
  input wire logic gate_polarity,
  input wire logic pin_level,
  input wire logic cmp1_level,
  input wire logic cmp2_level,
  gtm_gate_if.src gate
);

  typedef struct packed {
    logic [`GTM_T2_W-1:0] t2_count;
    logic match_pulse;
    logic gate;
  } gtm_sel_state_t;

  gtm_sel_state_t st_ff;
  gtm_sel_state_t nxt_st;
  logic raw;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.match_pulse = 1'b0;
    if (t2_enable) begin
      if (st_ff.t2_count == second_timer_period) begin
        nxt_st.t2_count = `GTM_T2_RST;
        nxt_st.match_pulse = 1'b1;
      end else begin
        nxt_st.t2_count = st_ff.t2_count + 8'h01;
      end
    end
    case (gate_source_select)
      `GTM_SRC_PIN: raw = pin_level;
      `GTM_SRC_T2_MATCH: raw = st_ff.match_pulse;
      `GTM_SRC_CMP1: raw = cmp1_level;
      `GTM_SRC_CMP2: raw = cmp2_level;
      default: raw = 1'b0;
    endcase
    nxt_st.gate = raw ^ gate_polarity;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gate.gate_level = st_ff.gate;

endmodule

`default_nettype wire

// ===== gtm_gate_src.sv
`default_nettype none
module gtm_gate_src (
  input wire logic [2:0] lv,
  output logic pin,
  output logic c1,
  output logic c2
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels change only at bench edges, so the design's synchronisers see clean steps
  assign {c2, c1, pin} = lv;
endmodule
`default_nettype wire

// ===== gtm_pkg.sv
`default_nettype none

package gtm_pkg;

  typedef enum logic [1:0] {
    GTM_PM_PRIMARY_RUN,
    GTM_PM_SECONDARY_RUN,
    GTM_PM_SECONDARY_IDLE,
    GTM_PM_SLEEP
  } gtm_pm_t;

endpackage

`default_nettype wire

// ===== gtm_timer.sv
`include "gtm_consts.svh"
`default_nettype none

module gtm_timer #(
  parameter int COUNT_W = `GTM_COUNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timer_on,
  input wire logic gate_enable,
  input wire logic [1:0] gate_source_select,
  input wire logic gate_polarity,
  input wire logic gate_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic t2_enable,
  input wire logic [`GTM_T2_W-1:0] second_timer_period,
  input wire logic overflow_flag_clear,
  input wire logic overflow_irq_enable,
  input wire logic [7:0] osc_control_reg,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic fscm_enable,
  input wire logic sosc_failed,
  input wire logic [1:0] secondary_drive_select,
  output logic [COUNT_W-1:0] main_count_pair,
  output logic overflow_flag,
  output logic overflow_irq,
  output logic [7:0] osc_control_reg_two,
  output logic secondary_clock_active,
  output gtm_pkg::gtm_pm_t pm_state,
  output logic sosc_drive_low,
  output logic sosc_drive_high
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic flag;
    gtm_pkg::gtm_pm_t pm;
    logic sosc_active;
    logic drive_low;
    logic drive_high;
    logic [1:0] pin_sync;
    logic [1:0] c1_sync;
    logic [1:0] c2_sync;
  } gtm_state_t;

  // ----------------------------------------
  // Reset and limit values
  // ----------------------------------------
  localparam gtm_state_t ST_RST = '{
    count: COUNT_W'(`GTM_COUNT_RST),
    flag: 1'b0,
    pm: gtm_pkg::GTM_PM_PRIMARY_RUN,
    sosc_active: 1'b0,
    drive_low: 1'b0,
    drive_high: 1'b0,
    pin_sync: 2'h0,
    c1_sync: 2'h0,
    c2_sync: 2'h0
  };
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  gtm_state_t st_ff;
  gtm_state_t nxt_st;
  logic gate_open;
  logic count_en;
  logic wrap;
  logic flag_set;
  logic flag_clr;
  logic sosc_selected;
  logic sleep_to_idle;
  logic sleep_to_stop;
  logic clock_handed_over;

  gtm_gate_if gate_bus ();

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic sosc_clocks(input gtm_pkg::gtm_pm_t pm);
    return (pm == gtm_pkg::GTM_PM_SECONDARY_RUN) || (pm == gtm_pkg::GTM_PM_SECONDARY_IDLE);
  endfunction

  function automatic logic osc_wants_secondary(input logic [7:0] ctl);
    return ctl[1:0] == `GTM_SCS_SECONDARY;
  endfunction

  // One compare serves both drive outputs, so the two codes stay consistent
  function automatic logic drive_is(input logic [1:0] sel, input logic [1:0] code);
    return sel == code;
  endfunction

  function automatic logic at_top(input logic [COUNT_W-1:0] cnt);
    return cnt == COUNT_W'(`GTM_COUNT_MAX);
  endfunction

  // ----------------------------------------
  // Gate path
  // ----------------------------------------
  // Pin and comparators are asynchronous, so only the second stage reaches the mux
  gtm_gate_sel u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .t2_enable(t2_enable),
    .second_timer_period(second_timer_period),
    .gate_source_select(gate_source_select),
    .gate_polarity(gate_polarity),
    .pin_level(st_ff.pin_sync[1]),
    .cmp1_level(st_ff.c1_sync[1]),
    .cmp2_level(st_ff.c2_sync[1]),
    .gate(gate_bus.src)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_sync = {st_ff.pin_sync[0], gate_input_pin};
    nxt_st.c1_sync = {st_ff.c1_sync[0], cmp1_out};
    nxt_st.c2_sync = {st_ff.c2_sync[0], cmp2_out};

    // ----------------------------------------
    // Count and overflow flag
    // ----------------------------------------
    // A closed gate only holds the count, it never clears it
    gate_open = ~gate_enable | gate_bus.gate_level;
    count_en = timer_on & gate_open;
    wrap = count_en & at_top(st_ff.count);
    if (count_en) begin
      nxt_st.count = st_ff.count + COUNT_ONE;
    end
    flag_set = wrap;
    flag_clr = overflow_flag_clear;
    // Set beats a clear landing in the same cycle
    if (flag_set) begin
      nxt_st.flag = 1'b1;
    end else if (flag_clr) begin
      nxt_st.flag = 1'b0;
    end

    // ----------------------------------------
    // Power states
    // ----------------------------------------
    sosc_selected = osc_wants_secondary(osc_control_reg);
    sleep_to_idle = sleep_exec & ~osc_control_reg[`GTM_IDLE_BIT];
    sleep_to_stop = sleep_exec & osc_control_reg[`GTM_IDLE_BIT];
    case (st_ff.pm)
      gtm_pkg::GTM_PM_PRIMARY_RUN: begin
        if (sosc_selected) begin
          nxt_st.pm = gtm_pkg::GTM_PM_SECONDARY_RUN;
        end
      end
      gtm_pkg::GTM_PM_SECONDARY_RUN: begin
        if (!sosc_selected) begin
          nxt_st.pm = gtm_pkg::GTM_PM_PRIMARY_RUN;
        end else if (sleep_to_idle) begin
          nxt_st.pm = gtm_pkg::GTM_PM_SECONDARY_IDLE;
        end else if (sleep_to_stop) begin
          nxt_st.pm = gtm_pkg::GTM_PM_SLEEP;
        end
      end
      gtm_pkg::GTM_PM_SECONDARY_IDLE, gtm_pkg::GTM_PM_SLEEP: begin
        if (wake_event) begin
          nxt_st.pm = gtm_pkg::GTM_PM_SECONDARY_RUN;
        end
      end
      default: nxt_st.pm = gtm_pkg::GTM_PM_PRIMARY_RUN;
    endcase

    // ----------------------------------------
    // Clock status and drive level
    // ----------------------------------------
    // A failed oscillator under the monitor hands the clock to another source
    clock_handed_over = fscm_enable & sosc_failed;
    nxt_st.sosc_active = sosc_clocks(nxt_st.pm) & ~clock_handed_over;
    // Registered so the drive outputs never glitch while the setting changes
    nxt_st.drive_low = drive_is(secondary_drive_select, `GTM_DRIVE_LOW);
    nxt_st.drive_high = drive_is(secondary_drive_select, `GTM_DRIVE_HIGH);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign main_count_pair = st_ff.count;
  assign overflow_flag = st_ff.flag;
  // Left combinational so that clearing the enable blocks the request at once
  assign overflow_irq = st_ff.flag & overflow_irq_enable;
  assign secondary_clock_active = st_ff.sosc_active;
  assign pm_state = st_ff.pm;
  assign sosc_drive_low = st_ff.drive_low;
  assign sosc_drive_high = st_ff.drive_high;
  always_comb begin
    osc_control_reg_two = 8'h00;
    osc_control_reg_two[`GTM_SOSC_ACTIVE_BIT] = st_ff.sosc_active;
  end

endmodule

`default_nettype wire

// ===== gtm_timer_monitor.sv
`default_nettype none
module gtm_timer_monitor #(
  parameter int COUNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timer_on,
  input wire logic gate_enable,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic [7:0] osc_control_reg,
  input wire logic sleep_exec,
  input wire logic fscm_enable,
  input wire logic sosc_failed,
  input wire logic [1:0] secondary_drive_select,
  input wire logic [COUNT_W-1:0] main_count_pair,
  input wire logic overflow_flag,
  input wire logic overflow_irq,
  input wire logic [7:0] osc_control_reg_two,
  input wire logic secondary_clock_active,
  input wire gtm_pkg::gtm_pm_t pm_state,
  input wire logic sosc_drive_low,
  input wire logic sosc_drive_high
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Ungated run only, the gate path adds latency that is checked by the bench
  wire logic run = timer_on && !gate_enable;
  chk_count_step: assert property (
    run |=> main_count_pair == COUNT_W'($past(main_count_pair) + 1))
    else $error("count did not step by one");
  chk_flag_set: assert property (run && main_count_pair == '1 |=> overflow_flag)
    else $error("overflow flag not set");
  chk_flag_sticky: assert property (
    overflow_flag && !overflow_flag_clear |=> overflow_flag)
    else $error("overflow flag dropped without a clear");
  chk_flag_clear: assert property (
    overflow_flag_clear && main_count_pair != '1 |=> !overflow_flag)
    else $error("overflow flag not cleared");
  chk_irq_gate: assert property (overflow_irq == (overflow_flag && overflow_irq_enable))
    else $error("overflow request mismatch");
  chk_secondary_run_state: assert property (
    osc_control_reg[1:0] == 2'h1 && pm_state == 2'h0 |=> pm_state == 2'h1)
    else $error("secondary run not entered");
  chk_secondary_idle_state: assert property (
    osc_control_reg[1:0] == 2'h1 && pm_state == 2'h1 && sleep_exec && !osc_control_reg[7]
    |=> pm_state == 2'h2)
    else $error("secondary idle not entered");
  chk_status_bit: assert property (
    osc_control_reg_two == {1'b0, secondary_clock_active, 6'h00})
    else $error("status register bit mismatch");
  chk_active_state: assert property (
    secondary_clock_active |-> (pm_state == 2'h1 || pm_state == 2'h2))
    else $error("status active outside the secondary states");
  chk_failsafe_src: assert property (
    (fscm_enable && sosc_failed) [*2] |-> !secondary_clock_active)
    else $error("failed oscillator still shown active");
  chk_drive_decode: assert property (
    {sosc_drive_high, sosc_drive_low} ==
    {$past(secondary_drive_select) == 2'h3, $past(secondary_drive_select) == 2'h1})
    else $error("drive decode mismatch");
  cover property (run && main_count_pair == '1);
  cover property (pm_state == 2'h2);
  cover property (pm_state == 2'h3);
  cover property (fscm_enable && sosc_failed && pm_state != 2'h0);
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, timer_on = 0, gate_enable = 0, gate_polarity = 0, t2_enable = 0;
  logic overflow_flag_clear = 0, overflow_irq_enable = 0, sleep_exec = 0, wake_event = 0;
  logic fscm_enable = 0, sosc_failed = 0, gate_input_pin, cmp1_out, cmp2_out, l;
  logic [1:0] gate_source_select = 0, secondary_drive_select = 0;
  logic [7:0] second_timer_period = 0, osc_control_reg = 0, osc_control_reg_two;
  logic [2:0] lv = 0;
  logic [15:0] main_count_pair, c0;
  logic overflow_flag, overflow_irq, secondary_clock_active, sosc_drive_low, sosc_drive_high;
  gtm_pkg::gtm_pm_t pm_state;
  int fails = 0, n_compared = 0, k;
  always #50 clk = ~clk;
  gtm_timer uut (.clk, .rst_n, .timer_on, .gate_enable, .gate_source_select, .gate_polarity,
    .gate_input_pin, .cmp1_out, .cmp2_out, .t2_enable, .second_timer_period,
    .overflow_flag_clear, .overflow_irq_enable, .osc_control_reg, .sleep_exec, .wake_event,
    .fscm_enable, .sosc_failed, .secondary_drive_select, .main_count_pair, .overflow_flag,
    .overflow_irq, .osc_control_reg_two, .secondary_clock_active, .pm_state,
    .sosc_drive_low, .sosc_drive_high);
  gtm_gate_src src (.lv, .pin(gate_input_pin), .c1(cmp1_out), .c2(cmp2_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] gate_exp(input logic lvl, input logic pol);
    return (lvl ^ pol) ? 16'h0014 : 16'h0000;
  endfunction
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    k = $urandom(32'ha66c9091);
    repeat (16) @(posedge clk);
    rst_n <= 1;
    for (int d = 0; d < 4; d++) begin
      @(posedge clk) secondary_drive_select <= 2'(d);
      @(posedge clk);
      @(negedge clk) check({sosc_drive_high, sosc_drive_low}, {d == 3, d == 1}, "drive");
    end
    @(posedge clk) {timer_on, gate_enable} <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      l = 1'($urandom);
      @(posedge clk) begin
        gate_source_select <= (i < 2) ? 2'h0 : 2'(i / 2 + 1);
        gate_polarity <= i[0];
        lv <= l ? 3'(1 << (i / 2)) : 3'(7 ^ (1 << (i / 2)));
      end
      repeat (8) @(posedge clk);
      @(negedge clk) c0 = main_count_pair;
      repeat (20) @(posedge clk);
      @(negedge clk) check(main_count_pair - c0, gate_exp(l, i[0]), "gate");
    end
    @(posedge clk) {gate_source_select, gate_polarity, t2_enable} <= 4'h5;
    @(posedge clk) second_timer_period <= 8'h03;
    repeat (12) @(posedge clk);
    @(negedge clk) c0 = main_count_pair;
    repeat (40) @(posedge clk);
    @(negedge clk) check(main_count_pair - c0, 16'h000a, "match");
    @(posedge clk) gate_enable <= 0;
    @(negedge clk) check(overflow_flag, 0, "flag0");
    for (k = 0; k < 70000 && main_count_pair !== 16'hffff; k++) @(negedge clk);
    @(negedge clk) check(main_count_pair, 16'h0000, "wrap");
    check({overflow_flag, overflow_irq}, 2'h2, "flag_irq");
    @(posedge clk) overflow_irq_enable <= 1;
    repeat (5) @(posedge clk);
    @(negedge clk) check({overflow_flag, overflow_irq}, 2'h3, "sticky");
    @(posedge clk) overflow_flag_clear <= 1;
    @(posedge clk) overflow_flag_clear <= 0;
    @(negedge clk) check(overflow_flag, 0, "clear");
    @(posedge clk) osc_control_reg <= 8'h01;
    @(posedge clk);
    @(negedge clk) check(pm_state, gtm_pkg::GTM_PM_SECONDARY_RUN, "pm_run");
    check(osc_control_reg_two, 16'h0040, "status");
    @(posedge clk) sleep_exec <= 1;
    @(posedge clk) sleep_exec <= 0;
    @(negedge clk) check(pm_state, gtm_pkg::GTM_PM_SECONDARY_IDLE, "pm_idle");
    @(posedge clk) {fscm_enable, sosc_failed, wake_event} <= 3'h7;
    @(posedge clk) wake_event <= 0;
    @(posedge clk);
    @(negedge clk) check(secondary_clock_active, 0, "failsafe");
    @(posedge clk) {fscm_enable, sosc_failed, osc_control_reg} <= {2'h0, 8'h81};
    @(posedge clk) sleep_exec <= 1;
    @(posedge clk) sleep_exec <= 0;
    @(negedge clk) check(pm_state, gtm_pkg::GTM_PM_SLEEP, "pm_sleep");
    check(secondary_clock_active, 0, "sleep_off");
    @(posedge clk) {osc_control_reg, wake_event} <= {8'h00, 1'b1};
    @(posedge clk) wake_event <= 0;
    @(posedge clk);
    @(negedge clk) check(pm_state, gtm_pkg::GTM_PM_PRIMARY_RUN, "pm_back");
    check(osc_control_reg_two, 16'h0000, "status_off");
    final_report;
  end
  // Run is about 66000 cycles, dominated by the full count to wrap
  initial begin
    #(100 * 90000);
    fails++;
    final_report;
  end
endmodule
bind gtm_timer gtm_timer_monitor #(.COUNT_W(COUNT_W)) mon (.clk, .rst_n, .timer_on,
  .gate_enable, .overflow_irq_enable, .overflow_flag_clear, .osc_control_reg, .sleep_exec,
  .fscm_enable, .sosc_failed, .secondary_drive_select, .main_count_pair, .overflow_flag,
  .overflow_irq,
  .osc_control_reg_two, .secondary_clock_active, .pm_state, .sosc_drive_low, .sosc_drive_high);
`default_nettype wire
